// file: logic/fcpd_pkg.sv
/*
 * Constants for the floppy command and parameter decoder: opcodes, field
 * positions, reset values and delay units.
 * Assumes a 20 MHz controller clock.
 */
`default_nettype none
package fcpd_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int HEAD_UNIT_NS  = 1000000;                      // Head delay unit, 1 ms
	localparam int HEAD_UNIT_CYC = HEAD_UNIT_NS / CLK_PERIOD_NS; // Cycles per unit
	localparam int HLT_SCALE     = 1;                            // Units per settle count
	localparam int HUT_SCALE     = 16;                           // Units per release count
	// Opcode patterns and the bits that must match
	localparam logic [7:0] OP_READ = 8'h06, MK_READ = 8'h1F;
	localparam logic [7:0] OP_WRITE = 8'h05, MK_WRITE = 8'h3F;
	localparam logic [7:0] OP_VERIFY = 8'h16, MK_VERIFY = 8'h1F;
	localparam logic [7:0] OP_SPECIFY = 8'h03, OP_SENSE = 8'h08, OP_SEEK = 8'h0F;
	localparam logic [7:0] OP_RSEEK = 8'h8F, MK_RSEEK = 8'hBF;
	localparam logic [7:0] OP_CONFIG = 8'h13, OP_PERP = 8'h12;
	localparam logic [7:0] OP_LOCK = 8'h14, MK_LOCK = 8'h7F;
	// Field positions
	localparam int OPB_MFM = 6, OPB_DIR = 6, OPB_LOCK = 7;
	localparam int PB_EC = 7, PB_HDS = 2, CFG_EIS = 6, CFG_BUFFER_DISABLE_LOW = 5;
	localparam int PRP_OW = 7, PRP_D0 = 2, PRP_GAP = 1;
	// Parameter byte counts
	localparam logic [3:0] NP_RW = 4'h8, NP_TWO = 4'h2, NP_CFG = 4'h3;
	localparam logic [3:0] NP_ONE = 4'h1, NP_NONE = 4'h0;
	// Status and reset values
	localparam logic [7:0] ST0_INVALID = 8'h80, ST0_NORMAL = 8'h00;
	localparam logic       RST_BUFFER_DISABLE_LOW = 1'b1;
	localparam logic [3:0] RST_THR = 4'h0;
	localparam logic [7:0] RST_PRECOMP_START_TRACK = 8'h00;
	localparam logic [14:0] BASE_SECTOR = 15'h0080;
	typedef enum logic [3:0] {CK_INVALID, CK_READ, CK_WRITE, CK_VERIFY, CK_SPECIFY,
		CK_SENSE, CK_SEEK, CK_RSEEK, CK_CONFIG, CK_LOCK, CK_PERP} fcpd_cmd_t;
endpackage : fcpd_pkg
`default_nettype wire

// file: logic/fcpd_core.sv
/*
 * Command acceptance and parameter decoding for a floppy controller core.
 * Assumes host bytes arrive as one-cycle strobes, a seek engine and a data
 * engine answer with done pulses, and the byte engine supplies an index.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Bytes taken in command phase; opcode checked first
// - Bad opcode interrupts; sense reports invalid command
// - Cylinder is eight bits, 0 to 255
// - Perpendicular flag one marks drive perpendicular
// - Direction zero steps out, one steps in
// - Size code zero: 128 bytes, short length governs
// - Short tail: read dropped, write zeros, full CRC
// - Verify count flag makes length sectors per track
// - Buffer enable active low, disabled after reset
// - Implied seek before read or write when enabled
// - Last sector number ends multi-sector transfer
// - Gap bit alters gap 2; gap length sets gap 3
// - Head address selects head zero or one
// - Wait settle after load, release after execution
// - Lock keeps buffer settings over software reset
// - Density bit one MFM, zero FM
// - Sector size 128 times two to code, up to 7
module fcpd_core #(
	parameter int TICK_CYCLES = fcpd_pkg::HEAD_UNIT_CYC
) (
	input  wire logic        SYS_CLK,
	input  wire logic        ARST_N,
	input  wire logic        SOFT_RST,
	input  wire logic        HOST_WR,
	input  wire logic [7:0]  HOST_DATA,
	output logic             RQM,
	output logic             INT_REQ,
	output logic             INVALID_PEND,
	output logic [7:0]       SENSE_ST0,
	output logic             SENSE_DONE,
	output logic             SEEK_REQ,
	input  wire logic        SEEK_DONE,
	output logic             HEAD_LOAD,
	output logic             EXEC_GO,
	input  wire logic        EXEC_DONE,
	output logic             IS_WRITE,
	output logic [7:0]       CYLINDER,
	output logic             DRIVE_NUM,
	output logic             HEAD_NUMBER,
	output logic [7:0]       TRACK_LAST_SECTOR,
	output logic [2:0]       SIZE_CODE,
	output logic [7:0]       SHORT_SECTOR_LENGTH,
	output logic [14:0]      SECTOR_BYTES,
	output logic [14:0]      HOST_BYTES,
	output logic [7:0]       INTER_SECTOR_GAP_LEN,
	output logic             MFM_MODE,
	output logic             STEP_INWARD,
	output logic             COUNT_MODE_FLAG,
	output logic [7:0]       SECTORS_PER_TRACK,
	output logic [1:0]       PERPENDICULAR_DRIVE_FLAGS,
	output logic             GAP2_ALTER,
	output logic             BUFFER_DISABLE_LOW,
	output logic [3:0]       BUFFER_THRESHOLD,
	output logic [7:0]       PRECOMP_START_TRACK,
	output logic             IMPLIED_SEEK_ENABLE,
	output logic             LOCK_ON,
	input  wire logic        BYTE_STB,
	input  wire logic [14:0] BYTE_IDX,
	input  wire logic [7:0]  HOST_IN,
	output logic [7:0]       WR_BYTE,
	output logic             RD_PASS,
	output logic             CRC_EN
);
	import fcpd_pkg::*;

	typedef enum logic [2:0] {ST_OPCODE, ST_PARAM, ST_REJECT, ST_DECODE,
		ST_SEEK, ST_SETTLE, ST_EXEC} fcpd_state_t;

	fcpd_state_t state;
	fcpd_cmd_t   cmd;
	logic [7:0]  opcode;
	logic [7:0]  prm [8];
	logic [3:0]  pidx;
	logic [3:0]  plen;
	logic [6:0]  head_settle_delay;
	logic [3:0]  head_release_delay;
	logic [7:0]  settle_cnt;
	logic [7:0]  release_cnt;
	logic        releasing;
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
	logic        tick;
	logic        take_op;
	fcpd_cmd_t   op_kind;

	if (TICK_CYCLES < 1) begin : g_chk
		$error("TICK_CYCLES must be at least one");
	end

	// Opcode classification
	function automatic fcpd_cmd_t classify(input logic [7:0] op);
		if ((op & MK_READ) == OP_READ) return CK_READ;
		if ((op & MK_WRITE) == OP_WRITE) return CK_WRITE;
		if ((op & MK_VERIFY) == OP_VERIFY) return CK_VERIFY;
		if ((op & MK_RSEEK) == OP_RSEEK) return CK_RSEEK;
		if ((op & MK_LOCK) == OP_LOCK) return CK_LOCK;
		if (op == OP_SPECIFY) return CK_SPECIFY;
		if (op == OP_SENSE) return CK_SENSE;
		if (op == OP_SEEK) return CK_SEEK;
		if (op == OP_CONFIG) return CK_CONFIG;
		if (op == OP_PERP) return CK_PERP;
		return CK_INVALID;
	endfunction : classify

	// Parameter byte count per command
	function automatic logic [3:0] param_count(input fcpd_cmd_t k);
		unique case (k)
			CK_READ, CK_WRITE, CK_VERIFY: return NP_RW;
			CK_SPECIFY, CK_SEEK, CK_RSEEK: return NP_TWO;
			CK_CONFIG: return NP_CFG;
			CK_PERP: return NP_ONE;
			CK_INVALID, CK_SENSE, CK_LOCK: return NP_NONE;
			default: return NP_NONE; // Unused enum codes take no bytes
		endcase
	endfunction : param_count

	// Bytes are only requested while the command phase is open
	assign RQM     = (state == ST_OPCODE) || (state == ST_PARAM);
	assign take_op = HOST_WR && (state == ST_OPCODE);
	assign op_kind = classify(HOST_DATA);
	assign tick    = (tick_cnt == '0);

	// Delay unit divider
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
			tick_cnt <= '0;
		else if (tick)
			tick_cnt <= ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);
		else
			tick_cnt <= tick_cnt - 1'b1;

	// Command phase sequencing
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			state   <= ST_OPCODE;
			cmd     <= CK_INVALID;
			opcode  <= 8'h00;
			pidx    <= 4'h0;
			plen    <= 4'h0;
			EXEC_GO <= 1'b0;
			SEEK_REQ <= 1'b0;
		end
		else if (SOFT_RST)
		begin
			state    <= ST_OPCODE;
			EXEC_GO  <= 1'b0;
			SEEK_REQ <= 1'b0;
		end
		else
		begin
			EXEC_GO  <= 1'b0;
			SEEK_REQ <= 1'b0;
			unique case (state)
				ST_OPCODE:
					if (take_op)
					begin
						opcode <= HOST_DATA;
						cmd    <= op_kind;
						pidx   <= 4'h0;
						plen   <= param_count(op_kind);
						if (op_kind == CK_INVALID)
							state <= ST_REJECT;
						else if (param_count(op_kind) == NP_NONE)
							state <= ST_DECODE;
						else
							state <= ST_PARAM;
					end
				ST_PARAM:
					if (HOST_WR)
					begin
						pidx <= pidx + 1'b1;
						if (pidx + 1'b1 == plen)
							state <= ST_DECODE;
					end
				ST_REJECT:
					state <= ST_OPCODE;
				ST_DECODE:
					if (cmd == CK_READ || cmd == CK_WRITE || cmd == CK_VERIFY)
					begin
						if (IMPLIED_SEEK_ENABLE)
						begin
							state    <= ST_SEEK;
							SEEK_REQ <= 1'b1;
						end
						else
							state <= ST_SETTLE;
					end
					else
						state <= ST_OPCODE;
				ST_SEEK:
					if (SEEK_DONE)
						state <= ST_SETTLE;
				ST_SETTLE:
					if (settle_cnt == 8'h00)
					begin
						state   <= ST_EXEC;
						EXEC_GO <= 1'b1;
					end
				ST_EXEC:
					if (EXEC_DONE)
						state <= ST_OPCODE;
			endcase
		end

	// Parameter byte capture
	always_ff @(posedge SYS_CLK)
		if (state == ST_PARAM && HOST_WR)
			prm[pidx[2:0]] <= HOST_DATA;

	// Head settle wait before the transfer starts
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
			settle_cnt <= 8'h00;
		else if (state != ST_SETTLE)
			settle_cnt <= 8'(head_settle_delay * HLT_SCALE);
		else if (tick && settle_cnt != 8'h00)
			settle_cnt <= settle_cnt - 1'b1;

	// Head load and delayed release after execution
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			HEAD_LOAD   <= 1'b0;
			releasing   <= 1'b0;
			release_cnt <= 8'h00;
		end
		else if (state == ST_SETTLE)
		begin
			HEAD_LOAD <= 1'b1;
			releasing <= 1'b0;
		end
		else if (state == ST_EXEC && EXEC_DONE)
		begin
			releasing   <= 1'b1;
			release_cnt <= 8'(head_release_delay * HUT_SCALE);
		end
		else if (releasing && tick)
		begin
			if (release_cnt == 8'h00)
			begin
				HEAD_LOAD <= 1'b0;
				releasing <= 1'b0;
			end
			else
				release_cnt <= release_cnt - 1'b1;
		end

	// Invalid command status and sense answer; a new invalid beats the clear
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			INVALID_PEND <= 1'b0;
			SENSE_ST0    <= ST0_NORMAL;
			SENSE_DONE   <= 1'b0;
		end
		else
		begin
			SENSE_DONE <= 1'b0;
			if (take_op && op_kind == CK_INVALID)
				INVALID_PEND <= 1'b1;
			else if (state == ST_DECODE && cmd == CK_SENSE)
			begin
				SENSE_ST0    <= INVALID_PEND ? ST0_INVALID : ST0_NORMAL;
				SENSE_DONE   <= 1'b1;
				INVALID_PEND <= 1'b0;
			end
		end

	assign INT_REQ = INVALID_PEND;

	// Transfer, seek and specify command fields
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			IS_WRITE <= 1'b0;
			CYLINDER <= 8'h00;
			DRIVE_NUM <= 1'b0;
			HEAD_NUMBER <= 1'b0;
			TRACK_LAST_SECTOR <= 8'h00;
			SIZE_CODE <= 3'h0;
			SHORT_SECTOR_LENGTH <= 8'h00;
			SECTOR_BYTES <= BASE_SECTOR;
			HOST_BYTES <= BASE_SECTOR;
			INTER_SECTOR_GAP_LEN <= 8'h00;
			MFM_MODE <= 1'b0;
			STEP_INWARD <= 1'b0;
			COUNT_MODE_FLAG <= 1'b0;
			SECTORS_PER_TRACK <= 8'h00;
			head_settle_delay <= 7'h00;
			head_release_delay <= 4'h0;
		end
		else if (state == ST_DECODE)
		begin
			if (cmd == CK_SEEK || cmd == CK_RSEEK || cmd == CK_READ || cmd == CK_WRITE
				|| cmd == CK_VERIFY)
			begin
				DRIVE_NUM <= prm[0][0];
				CYLINDER  <= prm[1];
				HEAD_NUMBER <= prm[0][PB_HDS];
			end
			if (cmd == CK_RSEEK)
				STEP_INWARD <= opcode[OPB_DIR];
			if (cmd == CK_READ || cmd == CK_WRITE || cmd == CK_VERIFY)
			begin
				IS_WRITE <= (cmd == CK_WRITE);
				HEAD_NUMBER <= prm[2][0];
				MFM_MODE <= opcode[OPB_MFM];
				SIZE_CODE <= prm[4][2:0];
				TRACK_LAST_SECTOR <= prm[5];
				INTER_SECTOR_GAP_LEN <= prm[6];
				SHORT_SECTOR_LENGTH <= prm[7];
				SECTOR_BYTES <= BASE_SECTOR << prm[4][2:0];
				COUNT_MODE_FLAG <= (cmd == CK_VERIFY) && prm[0][PB_EC];
				if (cmd == CK_VERIFY && prm[0][PB_EC])
					SECTORS_PER_TRACK <= prm[7];
				// Short length only counts for code zero; else it is ignored
				if (prm[4][2:0] == 3'h0)
					HOST_BYTES <= (prm[7] > BASE_SECTOR[7:0]) ? BASE_SECTOR
						: {7'h00, prm[7]};
				else
					HOST_BYTES <= BASE_SECTOR << prm[4][2:0];
			end
			if (cmd == CK_SPECIFY)
			begin
				head_release_delay <= prm[0][3:0];
				head_settle_delay <= prm[1][7:1];
			end
		end

	// Configuration, lock and perpendicular settings
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			BUFFER_DISABLE_LOW <= RST_BUFFER_DISABLE_LOW;
			BUFFER_THRESHOLD <= RST_THR;
			PRECOMP_START_TRACK <= RST_PRECOMP_START_TRACK;
			IMPLIED_SEEK_ENABLE <= 1'b0;
			LOCK_ON <= 1'b0;
			PERPENDICULAR_DRIVE_FLAGS <= 2'h0;
			GAP2_ALTER <= 1'b0;
		end
		else if (SOFT_RST)
		begin
			if (!LOCK_ON)
			begin
				BUFFER_DISABLE_LOW <= RST_BUFFER_DISABLE_LOW;
				BUFFER_THRESHOLD <= RST_THR;
				PRECOMP_START_TRACK <= RST_PRECOMP_START_TRACK;
			end
		end
		else if (state == ST_DECODE)
		begin
			if (cmd == CK_CONFIG)
			begin
				IMPLIED_SEEK_ENABLE <= prm[1][CFG_EIS];
				BUFFER_DISABLE_LOW <= prm[1][CFG_BUFFER_DISABLE_LOW];
				BUFFER_THRESHOLD <= prm[1][3:0];
				PRECOMP_START_TRACK <= prm[2];
			end
			if (cmd == CK_LOCK)
				LOCK_ON <= opcode[OPB_LOCK];
			if (cmd == CK_PERP)
			begin
				GAP2_ALTER <= prm[0][PRP_GAP];
				if (prm[0][PRP_OW])
					PERPENDICULAR_DRIVE_FLAGS <= prm[0][PRP_D0+1:PRP_D0];
			end
		end

	// Sector tail handling: drop on read, zero fill on write, CRC over all
	always_ff @(posedge SYS_CLK or negedge ARST_N)
		if (!ARST_N)
		begin
			WR_BYTE <= 8'h00;
			RD_PASS <= 1'b0;
			CRC_EN  <= 1'b0;
		end
		else
		begin
			RD_PASS <= BYTE_STB && !IS_WRITE && (BYTE_IDX < HOST_BYTES);
			CRC_EN  <= BYTE_STB && (BYTE_IDX < SECTOR_BYTES);
			if (BYTE_STB)
				WR_BYTE <= (BYTE_IDX < HOST_BYTES) ? HOST_IN : 8'h00;
		end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	a_bad_op_int: assert property (take_op && op_kind == CK_INVALID && !SOFT_RST
		|=> INT_REQ && INVALID_PEND) else $error("invalid opcode did not interrupt");
	a_bad_op_noreq: assert property (take_op && op_kind == CK_INVALID && !SOFT_RST
		|=> !RQM ##1 RQM && INVALID_PEND) else $error("invalid opcode asked for bytes");
	a_sense_report: assert property (state == ST_DECODE && cmd == CK_SENSE
		&& INVALID_PEND && !SOFT_RST |=> SENSE_ST0 == ST0_INVALID && SENSE_DONE
		&& !INVALID_PEND) else $error("sense did not report invalid command");
	a_size_pow: assert property (SIZE_CODE != 3'h0 |-> SECTOR_BYTES ==
		(BASE_SECTOR << SIZE_CODE) && HOST_BYTES == SECTOR_BYTES)
		else $error("sector size does not follow size code");
	a_short_len: assert property (state == ST_DECODE && prm[4][2:0] == 3'h0
		&& (cmd == CK_READ || cmd == CK_WRITE || cmd == CK_VERIFY)
		&& prm[7] <= BASE_SECTOR[7:0] |=> SECTOR_BYTES == BASE_SECTOR
		&& HOST_BYTES == {7'h00, SHORT_SECTOR_LENGTH}) else $error("short length wrong");
	a_zero_fill: assert property (BYTE_STB && BYTE_IDX >= HOST_BYTES |=>
		WR_BYTE == 8'h00 && !RD_PASS) else $error("tail byte not dropped or zeroed");
	a_lock_reset: assert property (SOFT_RST && !LOCK_ON |=> BUFFER_DISABLE_LOW
		&& BUFFER_THRESHOLD == RST_THR) else $error("soft reset kept buffer settings");
	a_lock_hold: assert property (SOFT_RST && LOCK_ON |=>
		$stable(BUFFER_DISABLE_LOW) && $stable(BUFFER_THRESHOLD)
		&& $stable(PRECOMP_START_TRACK)) else $error("lock did not hold settings");
	a_settle_wait: assert property (state == ST_SETTLE && settle_cnt != 8'h00
		|=> !EXEC_GO) else $error("transfer started before head settled");
	a_implied_seek: assert property (state == ST_DECODE && cmd == CK_READ
		&& !SOFT_RST |=> SEEK_REQ == $past(IMPLIED_SEEK_ENABLE))
		else $error("implied seek request wrong");

endmodule : fcpd_core
`default_nettype wire

// file: bench/fcpd_host_model.sv
/*
 * Host-side model for the command decoder: writes command and parameter
 * bytes whenever ready is shown, and stands in for the seek and data engines.
 * Assumes one clock; the bench calls put_byte and may change exec_len.
 */
`timescale 1ns/100ps
`default_nettype none
module fcpd_host_model (
	input  wire logic       sys_clk,
	input  wire logic       rqm,
	output logic            host_wr,
	output logic [7:0]      host_data,
	input  wire logic       seek_req,
	output logic            seek_done,
	input  wire logic       exec_go,
	output logic            exec_done
);
	int exec_len = 5;   // Cycles from transfer start to its end
	int misses   = 0;   // Bytes dropped because ready never came

	// Idle levels at time zero
	initial
	begin
		host_wr   = 1'b0;
		host_data = 8'h00;
		seek_done = 1'b0;
		exec_done = 1'b0;
	end

	// One byte, written only while ready is up; the bus shows a changed value after
	task automatic put_byte(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge sys_clk);
		#1;
		while (rqm !== 1'b1 && n < 400)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 400)
			misses++;
		else
		begin
			host_wr   = 1'b1;   // Only in the command phase
			host_data = b;
			@(posedge sys_clk);
			#1;
			host_wr   = 1'b0;
			host_data = ~b;
		end
	endtask : put_byte

	// Seek engine: a requested seek ends three cycles later
	always @(posedge sys_clk)
		if (seek_req === 1'b1)
		begin
			repeat (3) @(posedge sys_clk);
			#1;
			seek_done = 1'b1;
			@(posedge sys_clk);
			#1;
			seek_done = 1'b0;
		end

	// Data engine: a started transfer ends exec_len cycles later
	always @(posedge sys_clk)
		if (exec_go === 1'b1)
		begin
			repeat (exec_len) @(posedge sys_clk);
			#1;
			exec_done = 1'b1;
			@(posedge sys_clk);
			#1;
			exec_done = 1'b0;
		end
endmodule : fcpd_host_model
`default_nettype wire

// file: bench/tb_fcpd_core.sv
/*
 * Self-checking bench for the command decoder: commands through the host
 * model, byte slots and soft reset from here. Assumes a 4-cycle head tick.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_fcpd_core;
	import fcpd_pkg::*;
	logic        clk, arst_n, soft_rst, host_wr, rqm, int_req, inv, sense_done, seek_req;
	logic        seek_done, head_load, exec_go, exec_done, is_wr, drv, head, mfm, step;
	logic        cmf, gap2, buf_dis, implied_seek_enable, lock_on, byte_stb, rd_pass, crc_en;
	logic [1:0]  perp;
	logic [2:0]  size;
	logic [3:0]  thr;
	logic [7:0]  host_data, st0, cyl, track_last_sector, ssl, inter_sector_gap_len, spt, pre, host_in, wr_byte;
	logic [14:0] sec_b, host_b, byte_idx;
	int          num_errors = 0, num_checks = 0, cycles = 0, seek_count = 0, cnt;

	fcpd_core #(.TICK_CYCLES(4)) u_fcpd_core (
		.SYS_CLK(clk), .ARST_N(arst_n), .SOFT_RST(soft_rst), .HOST_WR(host_wr),
		.HOST_DATA(host_data), .RQM(rqm), .INT_REQ(int_req), .INVALID_PEND(inv),
		.SENSE_ST0(st0), .SENSE_DONE(sense_done), .SEEK_REQ(seek_req), .SEEK_DONE(seek_done),
		.HEAD_LOAD(head_load), .EXEC_GO(exec_go), .EXEC_DONE(exec_done), .IS_WRITE(is_wr),
		.CYLINDER(cyl), .DRIVE_NUM(drv), .HEAD_NUMBER(head), .TRACK_LAST_SECTOR(track_last_sector),
		.SIZE_CODE(size), .SHORT_SECTOR_LENGTH(ssl), .SECTOR_BYTES(sec_b), .HOST_BYTES(host_b),
		.INTER_SECTOR_GAP_LEN(inter_sector_gap_len), .MFM_MODE(mfm), .STEP_INWARD(step), .COUNT_MODE_FLAG(cmf),
		.SECTORS_PER_TRACK(spt), .PERPENDICULAR_DRIVE_FLAGS(perp), .GAP2_ALTER(gap2),
		.BUFFER_DISABLE_LOW(buf_dis), .BUFFER_THRESHOLD(thr), .PRECOMP_START_TRACK(pre),
		.IMPLIED_SEEK_ENABLE(implied_seek_enable), .LOCK_ON(lock_on), .BYTE_STB(byte_stb), .BYTE_IDX(byte_idx),
		.HOST_IN(host_in), .WR_BYTE(wr_byte), .RD_PASS(rd_pass), .CRC_EN(crc_en)
	);

	fcpd_host_model u_fcpd_host_model (
		.sys_clk(clk), .rqm(rqm), .host_wr(host_wr), .host_data(host_data),
		.seek_req(seek_req), .seek_done(seek_done), .exec_go(exec_go), .exec_done(exec_done)
	);

	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Cycle ceiling against hangs, and implied seek counting
	always @(posedge clk)
	begin
		cycles++;
		if (seek_req === 1'b1)
			seek_count++;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	// Bounded wait for ready (0), transfer start (1) or head load (2) at a level
	task automatic wait_for(input int sel, input logic lvl, output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while ((sel == 0 ? rqm : sel == 1 ? exec_go : head_load) !== lvl && n < 200);
		`CHK(n < 200, 1'b1)
	endtask : wait_for

	// Opcode with up to three parameters, then wait for ready again
	task automatic cmd(input logic [7:0] a, input int k, input logic [7:0] b = 8'h00,
		input logic [7:0] c = 8'h00, input logic [7:0] d = 8'h00);
		logic [7:0] p [3];
		p = '{b, c, d};
		u_fcpd_host_model.put_byte(a);
		for (int i = 0; i < k; i++)
			u_fcpd_host_model.put_byte(p[i]);
		wait_for(0, 1'b1, cnt);
	endtask : cmd

	// Read, write or verify with its eight parameters
	task automatic rw(input logic [7:0] op, hd, c, n, last, gap, short_sector_length);
		logic [7:0] b [9];
		b = '{op, hd, c, {7'h00, hd[2]}, 8'h01, n, last, gap, short_sector_length};
		foreach (b[i])
			u_fcpd_host_model.put_byte(b[i]);
	endtask : rw

	// One byte slot a cycle after the call, so back-to-back slots drop the strobe low for one cycle between them;
	// outputs are read by the caller in the following cycle
	task automatic slot(input logic [14:0] idx, input logic [7:0] hi);
		@(posedge clk);
		#1;
		byte_stb = 1'b1;
		byte_idx = idx;
		host_in  = hi;
		@(posedge clk);
		#1;
		byte_stb = 1'b0;
		byte_idx = ~idx;
	endtask : slot

	// Software reset held for one edge
	task automatic sreset();
		soft_rst = 1'b1;
		@(posedge clk);
		#1;
		soft_rst = 1'b0;
	endtask : sreset

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// Main sequence
	initial
	begin
		arst_n   = 1'b0;
		soft_rst = 1'b0;
		byte_stb = 1'b0;
		byte_idx = 15'h0000;
		host_in  = 8'h00;
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b1;
		`CHK({rqm, buf_dis, sec_b}, {1'b1, RST_BUFFER_DISABLE_LOW, BASE_SECTOR})
		u_fcpd_host_model.put_byte(8'h00);
		`CHK({rqm, int_req, inv}, 3'b011)
		repeat (4) @(posedge clk);
		#1;
		`CHK(inv, 1'b1)
		u_fcpd_host_model.put_byte(OP_SENSE);
		@(posedge clk);
		#1;
		`CHK({sense_done, st0, int_req}, {1'b1, ST0_INVALID, 1'b0})
		cmd(OP_SENSE, 0);
		`CHK(st0, ST0_NORMAL)
		$display("test invalid done");
		cmd(OP_SPECIFY, 2, 8'h01, 8'h04);
		u_fcpd_host_model.exec_len = 40;
		rw(8'h46, 8'h05, 8'hFF, 8'h00, 8'h12, 8'h1B, 8'h40);
		wait_for(2, 1'b1, cnt);
		wait_for(1, 1'b1, cnt);
		`CHK(cnt >= 4, 1'b1)
		`CHK({cyl, drv, head}, {8'hFF, 1'b1, 1'b1})
		`CHK({track_last_sector, inter_sector_gap_len, mfm, is_wr}, {8'h12, 8'h1B, 1'b1, 1'b0})
		`CHK({size, ssl, host_b, sec_b}, {3'h0, 8'h40, 15'h0040, BASE_SECTOR})
		slot(15'h003F, 8'h00);
		`CHK({rd_pass, crc_en}, 2'b11)
		slot(15'h0040, 8'h00);
		`CHK({rd_pass, crc_en}, 2'b01)
		slot(15'h0080, 8'h00);
		`CHK({rd_pass, crc_en}, 2'b00)
		wait_for(0, 1'b1, cnt);
		repeat (56) @(posedge clk);
		#1;
		`CHK({head_load, seek_count}, {1'b1, 32'd0})
		wait_for(2, 1'b0, cnt);
		`CHK(cnt <= 20, 1'b1)
		$display("test read done");
		u_fcpd_host_model.exec_len = 5;
		rw(8'h16, 8'h80, 8'h10, 8'h00, 8'h09, 8'h1B, 8'h09);
		wait_for(0, 1'b1, cnt);
		`CHK({cmf, spt}, {1'b1, 8'h09})
		for (int n = 1; n < 8; n++)
		begin
			rw(8'h46, 8'h00, 8'h03, 8'(n), 8'h09, 8'h1B, 8'hFF);
			wait_for(0, 1'b1, cnt);
			`CHK({sec_b, host_b, drv}, {15'(128 << n), 15'(128 << n), 1'b0})
		end
		$display("test sizes done");
		cmd(OP_CONFIG, 3, 8'h00, 8'h45, 8'h22);
		`CHK({implied_seek_enable, buf_dis, thr, pre}, {1'b1, 1'b0, 4'h5, 8'h22})
		u_fcpd_host_model.exec_len = 30;
		rw(8'h05, 8'h00, 8'h07, 8'h00, 8'h09, 8'h1B, 8'h02);
		wait_for(1, 1'b1, cnt);
		slot(15'h0001, 8'hA5);
		`CHK({wr_byte, is_wr, mfm}, {8'hA5, 1'b1, 1'b0})
		slot(15'h0002, 8'hA5);
		`CHK({wr_byte, crc_en}, {8'h00, 1'b1})
		wait_for(0, 1'b1, cnt);
		`CHK(seek_count, 1)
		$display("test write done");
		cmd(OP_PERP, 1, 8'h86);
		`CHK({perp, gap2}, {2'b01, 1'b1})
		cmd(OP_PERP, 1, 8'h0A);
		`CHK(perp, 2'b01)
		cmd(8'hCF, 2, 8'h00, 8'h05);
		`CHK(step, 1'b1)
		cmd(OP_RSEEK, 2, 8'h00, 8'h05);
		`CHK(step, 1'b0)
		cmd(OP_SEEK, 2, 8'h05, 8'h2A);
		`CHK({cyl, drv, head}, {8'h2A, 1'b1, 1'b1})
		sreset();
		`CHK({buf_dis, thr, pre}, {RST_BUFFER_DISABLE_LOW, RST_THR, RST_PRECOMP_START_TRACK})
		cmd(8'h94, 0);
		cmd(OP_CONFIG, 3, 8'h00, 8'h45, 8'h22);
		sreset();
		`CHK({lock_on, buf_dis, thr, pre}, {1'b1, 1'b0, 4'h5, 8'h22})
		u_fcpd_host_model.put_byte(OP_CONFIG);
		sreset();
		u_fcpd_host_model.put_byte(OP_SENSE);
		@(posedge clk);
		#1;
		`CHK(sense_done, 1'b1)
		`CHK(u_fcpd_host_model.misses, 0)
		$display("test modes done");
		print_verdict();
	end
endmodule : tb_fcpd_core
`default_nettype wire
